// ===== include/sbs_pkg.sv
// Constants, types and reset values for the burst memory core.
// Assumes a single 200 MHz clock and a synchronous memory bus.
package sbs_pkg;
   localparam int ADDR_W       = 16;
   localparam int DATA_W       = 32;
   localparam int LANES        = 4;
   localparam int FIFO_DEPTH   = 16;
   localparam int FIFO_W       = ADDR_W + LANES + DATA_W;
   localparam int CLK_PERIOD_PS = 5000;
   // Sleep entry is a least time, recovery a longest time (in clock periods)
   localparam int SLEEP_ENTRY_PERIODS = 2;
   localparam int SLEEP_RECOV_PERIODS = 2;
   localparam int SLEEP_ENTRY_PS = SLEEP_ENTRY_PERIODS * CLK_PERIOD_PS;
   localparam int SLEEP_RECOV_PS = SLEEP_RECOV_PERIODS * CLK_PERIOD_PS;
   localparam int ENTRY_CYC_I = (SLEEP_ENTRY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RECOV_CYC_I = SLEEP_RECOV_PS / CLK_PERIOD_PS;
   localparam logic [1:0] ENTRY_LAST = 2'(ENTRY_CYC_I - 1);
   localparam logic [1:0] RECOV_LAST = 2'(RECOV_CYC_I - 1);
   localparam logic [3:0] ALL_LANES  = 4'hF;
   localparam logic [3:0] NO_LANES   = 4'h0;

   typedef enum logic [1:0] {SBS_RUN, SBS_ENTER, SBS_SLEEP, SBS_WAKE} sbs_mode_t;

   typedef struct packed {
      logic [1:0]        sync_sleep;
      logic [1:0]        sync_oe;
      logic [1:0]        sync_mode;
      sbs_mode_t         st;
      logic [1:0]        cnt;
      logic [ADDR_W-1:0] base;
      logic [1:0]        beat;
      logic              rd;
      logic [DATA_W-1:0] dq;
      logic              sleep_cur;
      logic              ready;
   } sbs_state_t;

   localparam sbs_state_t STATE_RST = '{sync_sleep: 2'h0, sync_oe: 2'h3, sync_mode: 2'h3,
      st: SBS_RUN, cnt: 2'h0, base: 16'h0000, beat: 2'h0, rd: 1'b0,
      dq: 32'h00000000, sleep_cur: 1'b0, ready: 1'b1};
endpackage

// ===== core/sbs_sram_ctrl.sv
// Synchronous burst memory core with sleep control and a write queue.
// Assumes bus pins are synchronous to i_ref_clk; sleep, output enable
// and burst mode pins are asynchronous and are synchronised here.
//
// Overview of operation
// RQ1: Sleep pin high keeps device deselected, powered down
// RQ2: Sleep request acts asynchronously, active high
// RQ3: Sleep lasts exactly while the pin stays high
// RQ4: Asleep device ignores clock and all inputs
// RQ5: Full sleep reached no earlier than two periods
// RQ6: Access pending at sleep entry may be lost
// RQ7: Controller finishes accesses before raising sleep
// RQ8: Normal operation resumes within two periods after wake
// RQ9: All three selects sampled together, all true
// RQ10: Output enable drives only after read start edge
// RQ11: Later burst beats use next internal address
// RQ12: Controller keeps output enable high around write data
// RQ13: Write to loaded address needs advance high
// RQ14: Full write by global write or gate plus lanes
// RQ15: Bus stays high impedance after write until strobe/advance
// RQ16: Either address strobe starts a new read
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Write queue
// ------------------------------------------------------------
module sbs_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         i_ref_clk,   // Clock
   input  wire logic         i_rst,       // Async reset, high
   input  wire logic         i_clk_en,    // Freezes state when low
   input  wire logic         i_in_valid,  // Push request
   output logic              o_in_ready,  // Space available
   input  wire logic [W-1:0] i_in_data,   // Push word
   output logic              o_out_valid, // Word available
   input  wire logic         i_out_ready, // Drain accepts
   output logic [W-1:0]      o_out_data   // Head word
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);
   localparam logic [CW-1:0] FULL = CW'(D);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
      logic          rdy;
   } sbs_fifo_t;
   sbs_fifo_t     q, d;
   logic [W-1:0]  mem [D];
   logic          push, pop;

   // Push and pop only on a real handshake so full and empty stay honest
   always_comb begin
      push = i_in_valid && q.rdy;
      pop  = (q.cnt != '0) && i_out_ready;
      d = q;
      if (push) begin
         d.wp = AW'(q.wp + 1'b1);
      end
      if (pop) begin
         d.rp = AW'(q.rp + 1'b1);
      end
      d.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
      d.rdy = (d.cnt != FULL);
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
      end else if (i_clk_en) begin
         q <= d;
      end
   end

   // Storage carries no reset
   always_ff @(posedge i_ref_clk) begin
      if (i_clk_en && push) begin
         mem[q.wp] <= i_in_data;
      end
   end

   assign o_in_ready  = q.rdy;
   assign o_out_valid = (q.cnt != '0);
   assign o_out_data  = mem[q.rp];
endmodule // sbs_fifo

// ------------------------------------------------------------
// Memory core
// ------------------------------------------------------------
module sbs_sram_ctrl (
   input  wire logic        i_ref_clk,                     // 200 MHz clock
   input  wire logic        i_rst,                         // Async reset, high
   input  wire logic        i_clk_en,                      // Freezes state when low
   input  wire logic        i_sleep_request,               // Async sleep pin, high
   input  wire logic        i_chip_select_n,               // Primary select, low
   input  wire logic        i_depth_expansion_select_n,    // Secondary select, low
   input  wire logic        i_depth_expansion_select,      // Secondary select, high
   input  wire logic        i_processor_address_strobe_n,  // Load strobe, low
   input  wire logic        i_controller_address_strobe_n, // Load strobe, low
   input  wire logic        i_burst_advance_n,             // Burst step, low
   input  wire logic        i_global_write_n,              // Full write, low
   input  wire logic        i_byte_write_gate_n,           // Lane gate, low
   input  wire logic [3:0]  i_byte_lane_write_n,           // Lane writes, low
   input  wire logic        i_output_enable_n,             // Async output enable
   input  wire logic        i_burst_interleaved,           // Async mode, high=interleaved
   input  wire logic [15:0] i_addr,                        // Address
   input  wire logic [31:0] i_dq,                          // Write data
   input  wire logic        i_mem_ready,                   // Array accepts queued write
   output logic [31:0]      o_dq,                          // Read data
   output logic             o_dq_oe,                       // Drive read data
   output logic             o_sleep_current,               // Full sleep reached
   output logic             o_ready,                       // Accepting accesses
   output logic             o_wr_ready                     // Write queue has room
);
   sbs_pkg::sbs_state_t            q, d;
   logic                           asleep_q, oe_q;
   logic [sbs_pkg::DATA_W-1:0]     mem [2**sbs_pkg::ADDR_W];
   logic                           sleep_s, active, sel, load, wr_any, push;
   logic [3:0]                     lanes;
   logic [sbs_pkg::ADDR_W-1:0]     cur_a, wr_a;
   logic                           f_valid;
   logic [sbs_pkg::FIFO_W-1:0]     f_data;

   // Burst address from the loaded base and the beat count
   function automatic logic [15:0] burst_addr(input logic [15:0] b, input logic [1:0] n,
                                              input logic il);
      burst_addr = {b[15:2], il ? (b[1:0] ^ n) : 2'(b[1:0] + n)};
   endfunction

   // ----------------------------------------------------------
   // Next state
   // ----------------------------------------------------------
   always_comb begin
      d = q;
      d.sync_sleep = {q.sync_sleep[0], i_sleep_request};
      d.sync_oe    = {q.sync_oe[0], i_output_enable_n};
      d.sync_mode  = {q.sync_mode[0], i_burst_interleaved};
      sleep_s = q.sync_sleep[1];
      // RQ3 sleep follows pin
      unique case (q.st)
         sbs_pkg::SBS_RUN: begin
            if (sleep_s) begin
               d.st = sbs_pkg::SBS_ENTER;
               d.cnt = 2'h0;
               d.ready = 1'b0;
            end
         end
         sbs_pkg::SBS_ENTER: begin
            // RQ5 two period entry
            if (!sleep_s) begin
               d.st = sbs_pkg::SBS_WAKE;
               d.cnt = 2'h0;
            end else if (q.cnt == sbs_pkg::ENTRY_LAST) begin
               d.st = sbs_pkg::SBS_SLEEP;
               d.sleep_cur = 1'b1;
            end else begin
               d.cnt = 2'(q.cnt + 1'b1);
            end
         end
         sbs_pkg::SBS_SLEEP: begin
            if (!sleep_s) begin
               d.st = sbs_pkg::SBS_WAKE;
               d.cnt = 2'h0;
               d.sleep_cur = 1'b0;
            end
         end
         sbs_pkg::SBS_WAKE: begin
            // RQ8 bounded recovery
            if (sleep_s) begin
               d.st = sbs_pkg::SBS_ENTER;
               d.cnt = 2'h0;
            end else if (q.cnt == sbs_pkg::RECOV_LAST) begin
               d.st = sbs_pkg::SBS_RUN;
               d.ready = 1'b1;
            end else begin
               d.cnt = 2'(q.cnt + 1'b1);
            end
         end
      endcase
      // RQ4 inputs ignored asleep; the async latch closes the gap before sync
      active = q.ready && (q.st == sbs_pkg::SBS_RUN) && !asleep_q;
      // RQ9 all selects sampled together
      sel = !i_chip_select_n && !i_depth_expansion_select_n && i_depth_expansion_select;
      // RQ16 either strobe loads
      load = active && sel && (!i_processor_address_strobe_n ||
                               !i_controller_address_strobe_n);
      // RQ14 full or lane writes
      lanes = !i_global_write_n ? sbs_pkg::ALL_LANES :
              (!i_byte_write_gate_n ? ~i_byte_lane_write_n : sbs_pkg::NO_LANES);
      wr_any = (lanes != sbs_pkg::NO_LANES);
      cur_a = burst_addr(q.base, q.beat, q.sync_mode[1]);
      wr_a = cur_a;
      push = 1'b0;
      if (!active) begin
         // RQ6 pending read dropped at sleep entry
         d.rd = 1'b0;
      end else if (load) begin
         d.base = i_addr;
         d.beat = 2'h0;
         // Processor strobe always reads; controller strobe reads unless writing
         d.rd = !i_processor_address_strobe_n || !wr_any;
      end else if (!i_controller_address_strobe_n && !sel) begin
         d.rd = 1'b0;
      end else if (wr_any) begin
         // RQ13 advance high writes loaded address
         if (!i_burst_advance_n) begin
            d.beat = 2'(q.beat + 1'b1);
         end
         wr_a = burst_addr(q.base, d.beat, q.sync_mode[1]);
         push = 1'b1;
         // RQ15 bus released after write
         d.rd = 1'b0;
      end else if (!i_burst_advance_n) begin
         // RQ11 next internal burst address
         d.beat = 2'(q.beat + 1'b1);
         d.rd = 1'b1;
      end
      d.dq = mem[burst_addr(d.base, d.beat, q.sync_mode[1])];
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= sbs_pkg::STATE_RST;
      end else if (i_clk_en) begin
         q <= d;
      end
   end

   // ----------------------------------------------------------
   // Asynchronous sleep capture and output enable
   // ----------------------------------------------------------
   // RQ2 async sleep entry; held until recovery ends
   always_ff @(posedge i_ref_clk or posedge i_rst or posedge i_sleep_request) begin
      if (i_rst) begin
         asleep_q <= 1'b0;
      end else if (i_sleep_request) begin
         asleep_q <= 1'b1;
      end else if (i_clk_en && (q.st == sbs_pkg::SBS_WAKE) && d.ready) begin
         asleep_q <= 1'b0;
      end
   end

   // RQ1 outputs released at once; RQ10 drive after read start edge
   always_ff @(posedge i_ref_clk or posedge i_rst or posedge i_sleep_request) begin
      if (i_rst) begin
         oe_q <= 1'b0;
      end else if (i_sleep_request) begin
         oe_q <= 1'b0;
      end else if (i_clk_en) begin
         oe_q <= d.rd && !q.sync_oe[1];
      end
   end

   // ----------------------------------------------------------
   // Write queue and array
   // ----------------------------------------------------------
   // A push is dropped when o_wr_ready is low; the controller must wait
   sbs_fifo #(.W(sbs_pkg::FIFO_W), .D(sbs_pkg::FIFO_DEPTH)) u_wq (
      .i_ref_clk   (i_ref_clk),
      .i_rst       (i_rst),
      .i_clk_en    (i_clk_en),
      .i_in_valid  (push),
      .o_in_ready  (o_wr_ready),
      .i_in_data   ({wr_a, lanes, i_dq}),
      .o_out_valid (f_valid),
      .i_out_ready (i_mem_ready),
      .o_out_data  (f_data)
   );

   // Per lane drain; reads do not see words still queued
   for (genvar g = 0; g < sbs_pkg::LANES; g++) begin : g_lane
      always_ff @(posedge i_ref_clk) begin
         if (i_clk_en && f_valid && i_mem_ready && f_data[32+g]) begin
            mem[f_data[51:36]][8*g +: 8] <= f_data[8*g +: 8];
         end
      end
   end

   assign o_dq            = q.dq;
   assign o_dq_oe         = oe_q;
   assign o_sleep_current = q.sleep_cur;
   assign o_ready         = q.ready;

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_sleep_bus_off:   assert property (asleep_q |-> !o_dq_oe) // RQ1
      else $error("bus driven while asleep");
   a_sleep_entry_min: assert property ($rose(o_sleep_current) |-> // RQ5
      $past(q.sync_sleep[1]) && $past(q.st) == sbs_pkg::SBS_ENTER)
      else $error("full sleep reached too early");
   a_sleep_holds:     assert property (q.st == sbs_pkg::SBS_SLEEP && q.sync_sleep[1] // RQ3
      |=> q.st == sbs_pkg::SBS_SLEEP)
      else $error("sleep left while pin high");
   a_asleep_frozen:   assert property (asleep_q |=> $stable(q.base)) // RQ4
      else $error("address loaded while asleep");
   // Pin low seen by the synchroniser, then four running edges to finish recovery
   a_wake_bound:      assert property ($fell(q.sync_sleep[1]) ##0 i_clk_en [*4] // RQ8
      |-> ##[0:2] o_ready)
      else $error("recovery too slow");
   // A strobe with any select false must leave the loaded address alone
   a_select_all:      assert property (i_clk_en && active // RQ9
      && (!i_processor_address_strobe_n || !i_controller_address_strobe_n)
      && (i_chip_select_n || i_depth_expansion_select_n || !i_depth_expansion_select)
      |=> $stable(q.base))
      else $error("load without full select");
   a_oe_after_edge:   assert property ($rose(o_dq_oe) |-> q.rd) // RQ10
      else $error("output driven before read edge");
   a_burst_step:      assert property (i_clk_en && active && !load && !wr_any // RQ11
      && !i_burst_advance_n && i_controller_address_strobe_n
      |=> q.beat == 2'($past(q.beat) + 1'b1))
      else $error("burst beat not stepped");
   a_full_write:      assert property (active && !i_global_write_n
      |-> lanes == sbs_pkg::ALL_LANES) // RQ14
      else $error("global write not full width");
   a_hiz_after_wr:    assert property (i_clk_en && push |=> !q.rd ##0 !o_dq_oe) // RQ15
      else $error("bus driven after write");
endmodule // sbs_sram_ctrl

`default_nettype wire

// ===== sim/sbs_ctrl_model.sv
// Bus master model for the burst memory core; drives every bus pin.
// Assumes a free-running clock; each cycle launches at a falling edge.
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_model (
   input  wire logic        i_ref_clk, // Core clock
   output var  logic [2:0]  o_sel,     // Select, secondary low, secondary high
   output var  logic        o_ps_n,    // Processor strobe
   output var  logic        o_cc_n,    // Controller strobe
   output var  logic        o_adv_n,   // Burst step
   output var  logic        o_gw_n,    // Global write
   output var  logic        o_gate_n,  // Lane gate
   output var  logic [3:0]  o_ln_n,    // Lane writes
   output var  logic        o_oe_n,    // Output enable
   output var  logic [15:0] o_addr,    // Address
   output var  logic [31:0] o_dq       // Write data
);
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   // Own random stream for pins that a cycle does not care about
   int seed = 78;
   // Deselected at time zero so nothing loads during reset
   initial begin
      {o_sel, o_ps_n, o_cc_n, o_adv_n, o_gw_n, o_gate_n, o_ln_n} = {3'h6, 5'h1F, 4'hF};
      {o_oe_n, o_addr, o_dq} = {1'h0, 16'h0000, 32'h00000000};
   end
   // One cycle: launch after the falling edge, hold through the rising edge
   task automatic put(input logic [2:0] s, input logic p, c, v, g, b, input logic [3:0] l,
                      input logic [15:0] a, input logic [31:0] d, input logic o);
      @(negedge i_ref_clk);
      {o_sel, o_ps_n, o_cc_n, o_adv_n, o_gw_n, o_gate_n, o_ln_n} = {s, p, c, v, g, b, l};
      {o_addr, o_oe_n} = {a, o};
      // Unwritten data toggles so a stale value never passes for valid
      o_dq = (g && (b || &l)) ? ~o_dq : d;
      @(posedge i_ref_clk);
      #1;
   endtask
   // Read load or burst step with output enable low
   task automatic rd(input logic [2:0] s, input logic p, c, v, input logic [15:0] a);
      logic [4:0] r;
      r = 5'($random(seed));
      // Random lane pins never form a write: a low gate comes with every lane high
      put(s, p, c, v, 1'h1, r[4], r[4] ? r[3:0] : 4'hF, a, 32'h00000000, 1'h0);
   endtask
   // Selected, no strobe, step or write; the address is a don't-care
   task automatic idle(input int n);
      repeat (n) rd(3'h1, 1'h1, 1'h1, 1'h1, 16'($random(seed)));
   endtask
   // Controller load, one write cycle, then a short gap
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic g, b, v,
                     input logic [3:0] l);
      // enable raised early: the core resynchronises it over two edges
      repeat (2) put(3'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, a, 32'h00000000, 1'h1);
      put(3'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'hF, a, 32'h00000000, 1'h1);
      // advance kept high: unless a stepped write is asked for
      put(3'h1, 1'h1, 1'h1, v, g, b, l, a, d, 1'h1);
      idle(3);
   endtask
endmodule // sbs_ctrl_model
`default_nettype wire

// ===== sim/test_sync_burst_sram_sleep_and_access_control.sv
// Self-checking bench for the burst memory core and its write queue.
// Assumes the bus master model in sbs_ctrl_model and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_sync_burst_sram_sleep_and_access_control;
   logic        clk = 1'h0;
   logic        rst = 1'h1;
   logic        clk_en = 1'h1;
   logic        run = 1'h1;
   logic        stall = 1'h0;
   logic        slp = 1'h0;
   logic        mode = 1'h1;
   logic        rnd = 1'h0;
   logic        drain = 1'h1;
   logic        mem_ready = 1'h1;
   int          seed = 78;
   int          failures = 0;
   int          total_checks = 0;
   logic [15:0] b, c;
   logic [31:0] mem [int];
   logic [5:0]  lt [3] = '{6'h1F, 6'h20, 6'h2A};
   wire  [2:0]  sel;
   wire         ps_n, cc_n, adv_n, gw_n, gate_n, oe_n, dq_oe, slp_cur, ready, wr_ready;
   wire  [3:0]  ln_n;
   wire  [15:0] addr;
   wire  [31:0] dq_w, dq;
   // ----------------------------------------
   // Clock, stall source and instances
   // ----------------------------------------
   always #2.5 clk = ~clk;
   // Random stalls on the array side keep the queue partly full
   always @(negedge clk) mem_ready <= rnd ? 1'($random(seed)) : drain;
   // Random clock-enable gaps while the queue drains; otherwise follows run
   always @(negedge clk) clk_en <= stall ? 1'($random(seed)) : run;
   sbs_ctrl_model u_m (.i_ref_clk(clk), .o_sel(sel), .o_ps_n(ps_n), .o_cc_n(cc_n),
      .o_adv_n(adv_n), .o_gw_n(gw_n), .o_gate_n(gate_n), .o_ln_n(ln_n), .o_oe_n(oe_n),
      .o_addr(addr), .o_dq(dq_w));
   sbs_sram_ctrl uut (.i_ref_clk(clk), .i_rst(rst), .i_clk_en(clk_en),
      .i_sleep_request(slp), .i_chip_select_n(sel[2]), .i_depth_expansion_select_n(sel[1]),
      .i_depth_expansion_select(sel[0]), .i_processor_address_strobe_n(ps_n),
      .i_controller_address_strobe_n(cc_n), .i_burst_advance_n(adv_n),
      .i_global_write_n(gw_n), .i_byte_write_gate_n(gate_n), .i_byte_lane_write_n(ln_n),
      .i_output_enable_n(oe_n), .i_burst_interleaved(mode), .i_addr(addr), .i_dq(dq_w),
      .i_mem_ready(mem_ready), .o_dq(dq), .o_dq_oe(dq_oe), .o_sleep_current(slp_cur),
      .o_ready(ready), .o_wr_ready(wr_ready));
   // ----------------------------------------
   // Reference model and helpers
   // ----------------------------------------
   // Burst order: xor when interleaved, add when linear, low two bits only
   function automatic logic [15:0] nxt(input logic [15:0] a, input int k);
      return {a[15:2], mode ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
   endfunction
   task automatic mw(input logic [15:0] a, input logic [31:0] d, input logic g, bg,
                     input logic [3:0] l);
      for (int i = 0; i < 4; i++)
         if (!g || (!bg && !l[i])) mem[a][8*i +: 8] = d[8*i +: 8];
   endtask
   task automatic chk(input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask
   // A full queue drops the write, so the model follows the room flag
   task automatic w(input logic [15:0] a, input logic [31:0] d, input logic g, bg, v,
                    input logic [3:0] l);
      logic ok;
      ok = wr_ready;
      u_m.wr(a, d, g, bg, v, l);
      if (ok) mw(v ? a : nxt(a, 1), d, g, bg, l);
      chk(32'(dq_oe), 32'h0);
   endtask
   task automatic rdchk(input logic [15:0] a, input logic p);
      u_m.rd(3'h1, p, ~p, 1'h1, a);
      chk(dq, mem[a]);
      chk(32'(dq_oe), 32'h1);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #20000;
      failures++;
      finish_test;
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      chk(32'({ready, dq_oe, slp_cur, wr_ready}), 32'h9);
      @(negedge clk);
      rst = 1'h0;
      u_m.idle(3);
      rnd = 1'h1;
      // bursts and stepped writes in both orders
      for (int m = 0; m < 2; m++) begin
         @(negedge clk);
         mode = m[0];
         u_m.idle(3);
         b = 16'($random(seed));
         for (int k = 0; k < 4; k++)
            w(k == 1 ? b : nxt(b, k), $random(seed), 1'h0, 1'h1, k != 1, 4'hF);
         u_m.idle(40);
         rdchk(b, 1'h0);
         for (int k = 1; k < 4; k++) begin
            u_m.rd(3'h1, 1'h1, 1'h1, 1'h0, 16'h0000);
            chk(dq, mem[nxt(b, k)]);
         end
      end
      // lane writes: global, gate with all lanes, gate with two lanes
      c = b ^ 16'h0040;
      for (int j = 0; j < 3; j++) begin
         w(c, $random(seed), lt[j][5], lt[j][4], 1'h1, lt[j][3:0]);
         u_m.idle(40);
         rdchk(c, 1'h1);
      end
      // select sampling: one false select blocks the load
      rdchk(b, 1'h0);
      rdchk(c, 1'h1);
      for (int i = 0; i < 3; i++) begin
         u_m.rd(3'h1 ^ 3'(1 << i), 1'h0, 1'h1, 1'h1, b);
         chk(dq, mem[c]);
      end
      u_m.rd(3'h6, 1'h1, 1'h0, 1'h1, b);
      chk(32'(dq_oe), 32'h0);
      // late enable: no drive right after the read edge
      repeat (3) u_m.put(3'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, b, 32'h0, 1'h1);
      u_m.rd(3'h1, 1'h0, 1'h1, 1'h1, b);
      chk(32'(dq_oe), 32'h0);
      u_m.idle(3);
      // Frozen clock enable must not load a new address
      rdchk(b, 1'h0);
      @(negedge clk);
      run = 1'h0;
      u_m.rd(3'h1, 1'h0, 1'h1, 1'h1, c);
      chk(dq, mem[b]);
      @(negedge clk);
      run = 1'h1;
      // Fill the queue past full with the array stalled, then drain
      {rnd, drain} = 2'h0;
      for (int i = 0; i < 17; i++) begin
         w(16'h0100 + 16'(i % 16), $random(seed), 1'h0, 1'h1, 1'h1, 4'hF);
         chk(32'(wr_ready), 32'(i < 15));
      end
      drain = 1'h1;
      stall = 1'h1;
      u_m.idle(60);
      stall = 1'h0;
      for (int i = 0; i < 16; i++) rdchk(16'h0100 + 16'(i), 1'h0);
      // drained first: sleep only after the queue and reads are done
      rdchk(b, 1'h0);
      @(negedge clk);
      slp = 1'h1;
      #1;
      chk(32'(dq_oe), 32'h0);
      tick(2);
      chk(32'(slp_cur), 32'h0);
      for (int i = 0; i < 8 && slp_cur !== 1'h1; i++) tick(1);
      chk(32'(slp_cur), 32'h1);
      chk(32'(ready), 32'h0);
      u_m.rd(3'h1, 1'h0, 1'h1, 1'h1, c);
      chk(32'(dq_oe), 32'h0);
      u_m.idle(20);
      chk(32'({slp_cur, ready}), 32'h2);
      @(negedge clk);
      slp = 1'h0;
      for (int i = 0; i < 5 && ready !== 1'h1; i++) tick(1);
      chk(32'({slp_cur, ready}), 32'h1);
      u_m.idle(3);
      rdchk(c, 1'h1);
      finish_test;
   end
endmodule // test_sync_burst_sram_sleep_and_access_control
`default_nettype wire
